// *** src/plc_defines.vh ***
// Timing counts, level codes and widths for the pulse-count LED level control
`ifndef PLC_DEFINES_VH
`define PLC_DEFINES_VH
`define PLC_CLK_MHZ 50
`define PLC_LATCH_TIMEOUT_US 500
`define PLC_LATCH_CYCLES (`PLC_LATCH_TIMEOUT_US * `PLC_CLK_MHZ)
`define PLC_OFF_TIMEOUT_US 500
`define PLC_OFF_CYCLES (`PLC_OFF_TIMEOUT_US * `PLC_CLK_MHZ)
`define PLC_SOFT_EXTRA_US 500
`define PLC_SOFT_EXTRA_CYCLES (`PLC_SOFT_EXTRA_US * `PLC_CLK_MHZ)
`define PLC_SOFT_START_US 150
`define PLC_SOFT_START_CYCLES (`PLC_SOFT_START_US * `PLC_CLK_MHZ)
`define PLC_PUMP_FREQ_MHZ 1
`define PLC_PUMP_HALF_CYCLES (`PLC_CLK_MHZ / (2 * `PLC_PUMP_FREQ_MHZ))
`define PLC_DEGLITCH_CYCLES 2
// Sized last-cycle counts for the counter compares; must track the products above
`define PLC_DEGLITCH_LAST 2'h1
`define PLC_LATCH_LAST 16'h61a7
`define PLC_LATCH_SOFT_LAST 16'hc34f
`define PLC_OFF_LAST 16'h61a7
`define PLC_SOFT_START_LAST 16'h1d4b
`define PLC_PUMP_HALF_LAST 6'h18
`define PLC_LEVEL_W 5
`define PLC_LEVEL_FULL 5'h00
`define PLC_LEVEL_LAST 5'h1f
`define PLC_CURRENT_W 6
`define PLC_CURRENT_MAX 6'h3c
`define PLC_CHANNELS 4
`define PLC_TIMER_W 16
`endif

// *** src/plc_level_ctrl.v ***
// Pulse-count LED level control: edge counter, latch, shutdown, pump and channel control
`timescale 1ns/100ps
`include "plc_defines.vh"
module plc_level_ctrl (
	input wire clk_sys,
	input wire sys_rst,
	input wire ctrlPin,
	input wire supplyLow,
	input wire supplyHigh,
	input wire [3:0] ledPresent,
	output reg pumpEnable_reg,
	output reg pumpFull_reg,
	output reg pumpClk_reg,
	output reg pumpMode15_reg,
	output reg testCurrentEn_reg,
	output reg [3:0] ledSinkEnable_reg,
	output reg [5:0] ledSinkCurrent_reg,
	output reg [4:0] levelCode_reg
);
	localparam ST_OFF = 2'h0;
	localparam ST_COUNT = 2'h1;
	localparam ST_LATCHED = 2'h2;

	// Half-milliamp units, 1 mA per code: code 0 = 30 mA (60), code 30 = 0 mA, code 31 = 0.5 mA (1)
	function [5:0] levelToCurrent;
		input [4:0] code;
		begin
			if (code == `PLC_LEVEL_LAST)
				levelToCurrent = 6'h01;
			else
				levelToCurrent = `PLC_CURRENT_MAX - {code, 1'b0};
		end
	endfunction

	wire pinClean;
	reg pinPrev_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [4:0] count_reg;
	reg [15:0] highCnt_reg;
	reg [15:0] lowCnt_reg;
	reg [15:0] softCnt_reg;
	reg [5:0] divCnt_reg;
	reg fromShutdown_reg;
	wire riseEdge;
	wire latchDone;
	wire offDone;

	plc_pin_filter uFilter (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pinIn(ctrlPin),
		.pinClean_reg(pinClean)
	);

	// Edge and timeouts are measured on the filtered pin only
	assign riseEdge = pinClean & ~pinPrev_reg;
	assign latchDone = fromShutdown_reg ?
		(highCnt_reg == `PLC_LATCH_SOFT_LAST) :
		(highCnt_reg == `PLC_LATCH_LAST);
	assign offDone = lowCnt_reg == `PLC_OFF_LAST;

	// High and low time counters saturate so a long level never rolls over
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pinPrev_reg <= 1'b0;
			highCnt_reg <= 16'h0000;
			lowCnt_reg <= 16'h0000;
		end else begin
			pinPrev_reg <= pinClean;
			if (!pinClean || riseEdge)
				highCnt_reg <= 16'h0000;
			else if (!latchDone && highCnt_reg != 16'hffff)
				highCnt_reg <= highCnt_reg + 16'h0001;
			if (pinClean)
				lowCnt_reg <= 16'h0000;
			else if (!offDone)
				lowCnt_reg <= lowCnt_reg + 16'h0001;
		end
	end

	// Link state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (riseEdge)
					state_next = ST_COUNT;
			end
			ST_COUNT: begin
				if (offDone)
					state_next = ST_OFF;
				else if (pinClean && latchDone)
					state_next = ST_LATCHED;
			end
			ST_LATCHED: begin
				if (offDone)
					state_next = ST_OFF;
				else if (riseEdge)
					state_next = ST_COUNT;
			end
			default: state_next = ST_OFF;
		endcase
	end

	// Counter, level register and pump enable
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= ST_OFF;
			count_reg <= `PLC_LEVEL_FULL;
			levelCode_reg <= `PLC_LEVEL_FULL;
			pumpEnable_reg <= 1'b0;
			fromShutdown_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			case (state_reg)
				ST_OFF: begin
					if (riseEdge) begin
						pumpEnable_reg <= 1'b1;
						levelCode_reg <= `PLC_LEVEL_FULL;
						count_reg <= `PLC_LEVEL_FULL;
						fromShutdown_reg <= 1'b1;
					end
				end
				ST_COUNT: begin
					if (offDone) begin
						pumpEnable_reg <= 1'b0;
						levelCode_reg <= `PLC_LEVEL_FULL;
						count_reg <= `PLC_LEVEL_FULL;
					end else if (riseEdge) begin
						// Natural 5-bit wrap turns edge 33 back into state 1
						count_reg <= count_reg + 5'h01;
					end else if (pinClean && latchDone) begin
						levelCode_reg <= count_reg;
						fromShutdown_reg <= 1'b0;
					end
				end
				ST_LATCHED: begin
					if (offDone) begin
						pumpEnable_reg <= 1'b0;
						levelCode_reg <= `PLC_LEVEL_FULL;
						count_reg <= `PLC_LEVEL_FULL;
					end else if (riseEdge) begin
						count_reg <= `PLC_LEVEL_FULL;
					end
				end
				default: begin
					pumpEnable_reg <= 1'b0;
				end
			endcase
		end
	end

	// Soft-start: full capability only after the start interval
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			softCnt_reg <= 16'h0000;
			pumpFull_reg <= 1'b0;
		end else if (!pumpEnable_reg) begin
			softCnt_reg <= 16'h0000;
			pumpFull_reg <= 1'b0;
		end else if (softCnt_reg == `PLC_SOFT_START_LAST) begin
			pumpFull_reg <= 1'b1;
		end else begin
			softCnt_reg <= softCnt_reg + 16'h0001;
		end
	end

	// Fixed 1 MHz pump clock, independent of the mode
	always @(posedge clk_sys) begin
		if (sys_rst || !pumpEnable_reg) begin
			divCnt_reg <= 6'h00;
			pumpClk_reg <= 1'b0;
		end else if (divCnt_reg == `PLC_PUMP_HALF_LAST) begin
			divCnt_reg <= 6'h00;
			pumpClk_reg <= ~pumpClk_reg;
		end else begin
			divCnt_reg <= divCnt_reg + 6'h01;
		end
	end

	// Mode choice with hysteresis: the two comparator flags never flip-flop the mode
	always @(posedge clk_sys) begin
		if (sys_rst || !pumpEnable_reg)
			pumpMode15_reg <= 1'b0;
		else if (supplyLow)
			pumpMode15_reg <= 1'b1;
		else if (supplyHigh)
			pumpMode15_reg <= 1'b0;
	end

	// Per-channel sink drive, gated by LED presence from the test current
	genvar ch;
	generate
		for (ch = 0; ch < `PLC_CHANNELS; ch = ch + 1) begin : gChan
			always @(posedge clk_sys) begin
				if (sys_rst)
					ledSinkEnable_reg[ch] <= 1'b0;
				else
					ledSinkEnable_reg[ch] <= pumpEnable_reg & ledPresent[ch];
			end
		end
	endgenerate

	// Shared current code and test current follow the pump enable
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ledSinkCurrent_reg <= 6'h00;
			testCurrentEn_reg <= 1'b0;
		end else begin
			testCurrentEn_reg <= pumpEnable_reg;
			ledSinkCurrent_reg <= pumpEnable_reg ? levelToCurrent(levelCode_reg) : 6'h00;
		end
	end
endmodule // plc_level_ctrl

// *** src/plc_pin_filter.v ***
// Synchroniser and deglitch filter for the single control pin
`timescale 1ns/100ps
`include "plc_defines.vh"
module plc_pin_filter (
	input wire clk_sys,
	input wire sys_rst,
	input wire pinIn,
	output reg pinClean_reg
);
	reg syncA_reg;
	reg syncB_reg;
	reg [1:0] stableCnt_reg;
	// Two-flop synchroniser; first stage feeds only the second
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
		end else begin
			syncA_reg <= pinIn;
			syncB_reg <= syncA_reg;
		end
	end
	// Accept a new level only after it is stable; shorter spikes are dropped
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			stableCnt_reg <= 2'h0;
			pinClean_reg <= 1'b0;
		end else if (syncB_reg == pinClean_reg) begin
			stableCnt_reg <= 2'h0;
		end else if (stableCnt_reg == `PLC_DEGLITCH_LAST) begin
			stableCnt_reg <= 2'h0;
			pinClean_reg <= syncB_reg;
		end else begin
			stableCnt_reg <= stableCnt_reg + 2'h1;
		end
	end
endmodule // plc_pin_filter

// *** test/plc_host_model.sv ***
// Host model pulsing the single control pin
`timescale 1ns/100ps
module plc_host_model (
	input wire clk_sys,
	output logic ctrlPin
);
	initial ctrlPin = 1'b0;
	// Low then high, 25 cycles each: a 1 MHz train, far slower than the 2-cycle levels the filter passes
	task automatic burst(input int n);
		repeat (n) begin
			ctrlPin = 1'b0;
			repeat (25) @(posedge clk_sys);
			#1;
			ctrlPin = 1'b1;
			repeat (25) @(posedge clk_sys);
			#1;
		end
	endtask
	// Pin released low; the bench decides how long it stays so
	task pinLow;
		ctrlPin = 1'b0;
	endtask
endmodule // plc_host_model

// *** test/plc_level_ctrl_properties.sv ***
// Port assertions for the pulse-count level control
`timescale 1ns/100ps
`include "plc_defines.vh"
module plc_level_ctrl_properties (
	input wire clk_sys,
	input wire sys_rst,
	input wire ctrlPin,
	input wire [3:0] ledPresent,
	input wire pumpEnable_reg,
	input wire pumpClk_reg,
	input wire testCurrentEn_reg,
	input wire [3:0] ledSinkEnable_reg,
	input wire [5:0] ledSinkCurrent_reg,
	input wire [4:0] levelCode_reg
);
	localparam int OFF_LIM = `PLC_OFF_CYCLES + 8;
	int lowCnt = 0;
	int highCnt = 0;
	// Raw pin run lengths; margin covers the filter delay
	always @(posedge clk_sys) begin
		lowCnt <= ctrlPin ? 0 : (lowCnt < 60000 ? lowCnt + 1 : lowCnt);
		highCnt <= !ctrlPin ? 0 : (highCnt < 60000 ? highCnt + 1 : highCnt);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_firstEdge;
		!pumpEnable_reg && $rose(ctrlPin) |-> ##[3:8] pumpEnable_reg;
	endproperty
	a_firstEdge: assert property (p_firstEdge) else $error("pump not started by edge");
	property p_latch;
		$changed(levelCode_reg) && pumpEnable_reg |-> highCnt >= `PLC_LATCH_CYCLES;
	endproperty
	a_latch: assert property (p_latch) else $error("level applied early");
	property p_off;
		lowCnt == OFF_LIM |-> !pumpEnable_reg;
	endproperty
	a_off: assert property (p_off) else $error("no shutdown after long low");
	property p_clear;
		$fell(pumpEnable_reg) |-> ##[0:1] levelCode_reg == 5'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("level kept in shutdown");
	property p_clkHigh;
		$rose(pumpClk_reg) ##25 pumpEnable_reg |-> $past(pumpClk_reg) && !pumpClk_reg;
	endproperty
	a_clkHigh: assert property (p_clkHigh) else $error("pump clock half period");
	property p_clkIdle;
		!pumpEnable_reg ##1 !pumpEnable_reg |-> !pumpClk_reg;
	endproperty
	a_clkIdle: assert property (p_clkIdle) else $error("pump clock while off");
	property p_test;
		$changed(pumpEnable_reg) |=> testCurrentEn_reg == $past(pumpEnable_reg);
	endproperty
	a_test: assert property (p_test) else $error("test current lag");
	property p_sink;
		pumpEnable_reg ##1 pumpEnable_reg |-> ledSinkEnable_reg == $past(ledPresent);
	endproperty
	a_sink: assert property (p_sink) else $error("channel enable mismatch");
	property p_cur;
		pumpEnable_reg ##1 pumpEnable_reg |-> ledSinkCurrent_reg ==
			(($past(levelCode_reg) == 5'h1f) ? 6'h01 : 6'h3c - {$past(levelCode_reg), 1'b0});
	endproperty
	a_cur: assert property (p_cur) else $error("sink current mapping");
	c_wrap: cover property (levelCode_reg == 5'h1f);
	c_start: cover property ($rose(pumpEnable_reg));
	c_shut: cover property ($fell(pumpEnable_reg));
endmodule // plc_level_ctrl_properties
bind plc_level_ctrl plc_level_ctrl_properties plc_level_ctrl_properties_inst (.clk_sys, .sys_rst, .ctrlPin,
	.ledPresent, .pumpEnable_reg, .pumpClk_reg, .testCurrentEn_reg, .ledSinkEnable_reg, .ledSinkCurrent_reg,
	.levelCode_reg);

// *** test/pulse_count_led_level_control_tb_top.sv ***
// Self-checking bench for the pulse-count LED level control
`timescale 1ns/100ps
`include "plc_defines.vh"
module pulse_count_led_level_control_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic supplyLow = 1'b0;
	logic supplyHigh = 1'b1;
	logic [3:0] ledPresent = 4'h5;
	wire ctrlPin, pumpEnable, pumpFull, pumpMode15, testCur;
	wire [3:0] sinkEn;
	wire [5:0] sinkCur;
	wire [4:0] code;
	int fails = 0;
	int checksDone = 0;
	int cycles = 0;
	always #10 clk_sys = ~clk_sys;
	plc_host_model plc_host_model_inst (.clk_sys(clk_sys), .ctrlPin(ctrlPin));
	plc_level_ctrl plc_level_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctrlPin(ctrlPin),
		.supplyLow(supplyLow), .supplyHigh(supplyHigh), .ledPresent(ledPresent), .pumpEnable_reg(pumpEnable),
		.pumpFull_reg(pumpFull), .pumpClk_reg(), .pumpMode15_reg(pumpMode15), .testCurrentEn_reg(testCur),
		.ledSinkEnable_reg(sinkEn), .ledSinkCurrent_reg(sinkCur), .levelCode_reg(code));
	task check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask
	// Inputs always move 1 ns after the edge
	task waitCycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task summarize;
		$display("checks %0d, mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// 34 edges from shutdown: wraps once, then waits out the longer latch
	task testStartup;
		plc_host_model_inst.burst(34);
		check(pumpEnable, 8'h01, "pump on");
		check(sinkCur, 8'h3c, "full scale at start");
		check(pumpFull, 8'h00, "soft start running");
		check(testCur, 8'h01, "test current on");
		check(code, 8'h00, "no level mid-burst");
		waitCycles(`PLC_LATCH_CYCLES + 20);
		check(code, 8'h00, "latch extended");
		waitCycles(`PLC_SOFT_EXTRA_CYCLES);
		check(code, 8'h01, "wrapped level");
		check(sinkCur, 8'h3a, "current step");
		check(pumpFull, 8'h01, "soft start over");
		$display("test startup done");
	endtask
	// New burst restarts at state 1; 32 edges reach the smallest current
	task testRelevel;
		ledPresent = 4'h3;
		plc_host_model_inst.burst(32);
		waitCycles(`PLC_LATCH_CYCLES + 20);
		check(code, 8'h1f, "last level");
		check(sinkCur, 8'h01, "smallest current");
		check(sinkEn, 8'h03, "unused channels off");
		$display("test relevel done");
	endtask
	task testMode;
		supplyHigh = 1'b0;
		supplyLow = 1'b1;
		waitCycles(60);
		check(pumpMode15, 8'h01, "boost mode");
		supplyLow = 1'b0;
		supplyHigh = 1'b1;
		waitCycles(60);
		check(pumpMode15, 8'h00, "unity mode");
		$display("test mode done");
	endtask
	task testShutdown;
		plc_host_model_inst.pinLow();
		waitCycles(`PLC_OFF_CYCLES + 20);
		check(pumpEnable, 8'h00, "pump off");
		check(code, 8'h00, "level cleared");
		check(sinkCur, 8'h00, "no current");
		$display("test shutdown done");
	endtask
	// Cycle ceiling well above the ~104k the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 120000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		waitCycles(6);
		sys_rst = 1'b0;
		waitCycles(2);
		testStartup();
		testRelevel();
		testMode();
		testShutdown();
		summarize();
	end
endmodule // pulse_count_led_level_control_tb_top
